/* rtl/frt_icu_pkg.sv */
// Purpose: constants for the free-running timer with four capture channels
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package frt_icu_pkg;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_COUNT     = 8'h04;
  localparam logic [7:0]  ADDR_CAP_CTRL  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h14;
  localparam logic [7:0]  ADDR_XFER_EN   = 8'h18;
  localparam logic [7:0]  ADDR_CAP0      = 8'h20;
  localparam int          CTRL_DIV_LSB   = 0;
  localparam int          CTRL_STOP_BIT  = 2;
  localparam int          CTRL_CLR_BIT   = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [7:0]  CAP_CTRL_RESET = 8'h00;
  localparam logic [4:0]  STAT_RESET     = 5'h00;
  localparam int          STAT_OVF_BIT   = 4;
  localparam int          NUM_CH         = 4;
  localparam logic [7:0]  OVF_IRQ_NUM    = 8'h13;
  // ratio select -> last prescale count (div 1,2,4,8)
  localparam logic [2:0]  DIV_LAST0      = 3'h0;
  localparam logic [2:0]  DIV_LAST1      = 3'h1;
  localparam logic [2:0]  DIV_LAST2      = 3'h3;
  localparam logic [2:0]  DIV_LAST3      = 3'h7;
  typedef enum logic [1:0] {
    EDGE_NONE    = 2'h0,
    EDGE_RISE    = 2'h1,
    EDGE_FALL    = 2'h2,
    EDGE_BOTH    = 2'h3
  } edge_sel_t;
endpackage : frt_icu_pkg

/* rtl/frt_icu.sv */
// Purpose: free-running 16-bit timer with four edge capture channels
// Assumes: capture pins synchronous to clk_i; single-cycle wishbone answer
// Notes: irq_o is the level request; ovf_irq_num_o names the vector of ovf_irq_o
module frt_icu
  import frt_icu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [3:0]  cap_pin_i,
  output logic      [15:0] count_o,
  output logic             irq_o,
  output logic             ovf_irq_o,
  output logic      [7:0]  ovf_irq_num_o,
  output logic             xfer_req_o
);
  logic [3:0]  ctrl_ff;
  logic [15:0] count_ff;
  logic [2:0]  pre_ff;
  logic [7:0]  cap_ctrl_ff;
  logic [4:0]  stat_ff;
  logic [4:0]  irq_en_ff;
  logic [4:0]  xfer_en_ff;
  logic [3:0]  pin_prev_ff;
  logic [15:0] cap_ff [NUM_CH];
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [3:0]  nxt_ctrl;
  logic [15:0] nxt_count;
  logic [2:0]  nxt_pre;
  logic [7:0]  nxt_cap_ctrl;
  logic [4:0]  nxt_stat;
  logic [4:0]  nxt_irq_en;
  logic [4:0]  nxt_xfer_en;
  logic [31:0] nxt_dat;
  logic        req;
  logic        wr;
  logic        rd;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_cap_ctrl;
  logic        wr_irq_en;
  logic        wr_irq_clr;
  logic        wr_xfer_en;
  logic        clr_req;
  logic        halted;
  logic        tick;
  logic        ovf;
  logic [2:0]  div_last;
  logic [3:0]  cap_hit;
  logic [4:0]  clr_mask;
  logic [4:0]  set_mask;
  logic [4:0]  pend;

  // byte address against a register offset
  function automatic logic reg_at(input logic [7:0] addr, input logic [7:0] offset);
    reg_at = (addr == offset);
  endfunction : reg_at

  // mode bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
                                    input logic cur);
    edge_hit = (mode[0] & ~prev & cur) | (mode[1] & prev & ~cur);
  endfunction : edge_hit

  // high byte kept unless its lane is selected
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] lanes);
    lane_merge = {lanes[1] ? data[15:8] : old[15:8], data[7:0]};
  endfunction : lane_merge

  // one request per ack; the ack cycle is not a new request
  assign req = cyc_i & stb_i & ~ack_ff;
  // writes need lane 0; it carries every field except the count high byte, which rides lane 1
  assign wr  = req & we_i & sel_i[0];
  assign rd  = req & ~we_i;

  assign wr_ctrl     = wr & reg_at(adr_i, ADDR_CTRL);
  assign wr_count    = wr & reg_at(adr_i, ADDR_COUNT);
  assign wr_cap_ctrl = wr & reg_at(adr_i, ADDR_CAP_CTRL);
  assign wr_irq_en   = wr & reg_at(adr_i, ADDR_IRQ_EN);
  assign wr_irq_clr  = wr & reg_at(adr_i, ADDR_IRQ_CLR);
  assign wr_xfer_en  = wr & reg_at(adr_i, ADDR_XFER_EN);
  assign clr_req     = wr_ctrl & dat_i[CTRL_CLR_BIT];
  assign halted      = ctrl_ff[CTRL_STOP_BIT];

  // clear bit is a strobe, never stored
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = {1'b0, dat_i[2:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_comb begin
    case (ctrl_ff[CTRL_DIV_LSB +: 2])
      2'h0:    div_last = DIV_LAST0;
      2'h1:    div_last = DIV_LAST1;
      2'h2:    div_last = DIV_LAST2;
      2'h3:    div_last = DIV_LAST3;
      default: div_last = DIV_LAST0;
    endcase
  end

  assign tick = ~halted & (pre_ff == div_last);
  assign ovf  = tick & (count_ff == 16'hFFFF);

  always_comb begin
    if (halted || tick) begin
      nxt_pre = 3'h0;
    end else begin
      nxt_pre = pre_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  // clear wins, load while halted, count and wrap
  always_comb begin
    nxt_count = count_ff;
    if (clr_req) begin
      nxt_count = COUNT_RESET;
    end else if (wr_count && halted) begin
      nxt_count = lane_merge(count_ff, dat_i, sel_i);
    end else if (tick) begin
      nxt_count = count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count_o = count_ff;

  // edge modes, two bits per channel
  always_comb begin
    nxt_cap_ctrl = cap_ctrl_ff;
    if (wr_cap_ctrl) begin
      nxt_cap_ctrl = dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_ctrl_ff <= CAP_CTRL_RESET;
    end else begin
      cap_ctrl_ff <= nxt_cap_ctrl;
    end
  end

  always_comb begin
    nxt_irq_en = irq_en_ff;
    if (wr_irq_en) begin
      nxt_irq_en = dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_ff <= STAT_RESET;
    end else begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  always_comb begin
    nxt_xfer_en = xfer_en_ff;
    if (wr_xfer_en) begin
      nxt_xfer_en = dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_en_ff <= STAT_RESET;
    end else begin
      xfer_en_ff <= nxt_xfer_en;
    end
  end

  // pin history for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_ff <= 4'h0;
    end else begin
      pin_prev_ff <= cap_pin_i;
    end
  end

  // edge select, one detector for each of the four channels
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cap_hit[i] = edge_hit(cap_ctrl_ff[2*i +: 2], pin_prev_ff[i], cap_pin_i[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cap_ff[i] <= COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cap_hit[i]) begin
          cap_ff[i] <= count_ff;
        end
      end
    end
  end

  // write-one clear, overflow on top bit
  assign clr_mask = wr_irq_clr ? dat_i[4:0] : 5'h00;
  assign set_mask = {ovf, cap_hit};

  always_comb begin
    nxt_stat = (stat_ff & ~clr_mask) | set_mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= STAT_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign pend          = stat_ff & irq_en_ff;
  assign irq_o         = |pend;
  assign ovf_irq_o     = pend[STAT_OVF_BIT];
  assign ovf_irq_num_o = OVF_IRQ_NUM;
  assign xfer_req_o    = |(pend & xfer_en_ff);

  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (adr_i)
      ADDR_CTRL:      nxt_dat = {29'h0, ctrl_ff[2:0]};
      ADDR_COUNT:     nxt_dat = {16'h0000, count_ff};
      ADDR_CAP_CTRL:  nxt_dat = {24'h000000, cap_ctrl_ff};
      ADDR_STATUS:    nxt_dat = {27'h0, stat_ff};
      ADDR_IRQ_EN:    nxt_dat = {27'h0, irq_en_ff};
      ADDR_XFER_EN:   nxt_dat = {27'h0, xfer_en_ff};
      ADDR_CAP0:      nxt_dat = {16'h0000, cap_ff[0]};
      ADDR_CAP0 + 8'h04: nxt_dat = {16'h0000, cap_ff[1]};
      ADDR_CAP0 + 8'h08: nxt_dat = {16'h0000, cap_ff[2]};
      ADDR_CAP0 + 8'h0C: nxt_dat = {16'h0000, cap_ff[3]};
      default:        nxt_dat = 32'h0000_0000;
    endcase
  end

  // answer one cycle after the request edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read data stands only with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (rd) begin
      dat_ff <= nxt_dat;
    end else begin
      dat_ff <= 32'h0000_0000;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
endmodule : frt_icu

/* bench/frt_icu_checker.sv */
// Purpose: port checks of the capture timer
// Assumes: one clock, synchronous reset
// Notes: bound from the bench top
module frt_icu_checker
  import frt_icu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [15:0] count_o,
  input wire logic        irq_o,
  input wire logic        ovf_irq_o,
  input wire logic [7:0]  ovf_irq_num_o,
  input wire logic        xfer_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  AST_IRQ_NUM: assert property (ovf_irq_num_o == 8'h13)
    else $error("wrong overflow request number");
  AST_OVF_IRQ: assert property (ovf_irq_o |-> irq_o)
    else $error("overflow request without irq");
  AST_XFER: assert property (xfer_req_o |-> irq_o)
    else $error("transfer request without irq");
  AST_STEP: assert property (!ack_o |-> count_o == $past(count_o) || count_o == $past(count_o) + 16'h1)
    else $error("counter jumped");
  AST_RST_CLR: assert property (disable iff (1'b0) rst_i |=> count_o == 16'h0000 && !irq_o)
    else $error("reset did not clear");
  cover property (ovf_irq_o);
  cover property (xfer_req_o);
  cover property (ack_o ##3 ack_o);
  cover property (irq_o && !ovf_irq_o);
endmodule : frt_icu_checker

/* bench/cap_source.sv */
// Purpose: external sources on the capture pins
// Assumes: levels launched after a clock edge
// Notes: pins follow the request one edge later
module cap_source (
  input  wire logic       clk_i,
  input  wire logic [3:0] want_i,
  output logic      [3:0] pin_o = 4'h2
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    pin_o <= want_i;
  end
endmodule : cap_source

/* bench/free_run_timer_input_capture_bench.sv */
// Purpose: register-level test of the capture timer
// Assumes: one-cycle wishbone answer
// Notes: pins driven through the source model
module free_run_timer_input_capture_bench;
  import frt_icu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rdat;
  logic [3:0]  want = 4'h2;
  logic [3:0]  pins;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] count_o;
  logic        irq_o;
  logic        ovf_irq_o;
  logic [7:0]  num;
  logic        xfer;
  int          err_total = 0;
  int          num_checks = 0;
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  frt_icu u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .cap_pin_i(pins), .count_o(count_o),
    .irq_o(irq_o), .ovf_irq_o(ovf_irq_o), .ovf_irq_num_o(num), .xfer_req_o(xfer));
  cap_source u_src (.clk_i(clk_i), .want_i(want), .pin_o(pins));
  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    int n = 0;
    cyc <= 1'b1;
    sel <= s;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  initial begin
    int c;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(num), 32'h13);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'hC);
    rd(ADDR_COUNT, 32'h0);
    bus(1'b1, ADDR_COUNT, 32'hABCD, 4'h1);
    rd(ADDR_COUNT, 32'h00CD);
    bus(1'b1, ADDR_COUNT, 32'hFFFE);
    rd(ADDR_COUNT, 32'hFFFE);
    bus(1'b1, ADDR_IRQ_EN, 32'h1F);
    bus(1'b1, ADDR_XFER_EN, 32'h10);
    bus(1'b1, ADDR_CTRL, 32'h0);
    @(posedge clk_i);
    chk(32'({ovf_irq_o, xfer, irq_o}), 32'h7);
    rd(ADDR_STATUS, 32'h10);
    bus(1'b1, ADDR_IRQ_CLR, 32'h10);
    bus(1'b1, ADDR_IRQ_EN, 32'h0);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h4);
    bus(1'b1, ADDR_COUNT, 32'h1234);
    bus(1'b1, ADDR_CAP_CTRL, 32'h39);
    want <= 4'hD;
    repeat (3) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h7);
    for (int i = 0; i < 4; i++) rd(ADDR_CAP0 + 8'(4 * i), (i < 3) ? 32'h1234 : 32'h0);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, ADDR_IRQ_CLR, 32'hF);
    want <= 4'h0;
    repeat (3) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h4);
    bus(1'b1, ADDR_IRQ_EN, 32'h4);
    bus(1'b1, ADDR_XFER_EN, 32'h4);
    chk(32'({irq_o, xfer}), 32'h3);
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, ADDR_CTRL, 32'(4 + d));
      bus(1'b1, ADDR_COUNT, 32'h0);
      bus(1'b1, ADDR_CTRL, 32'(d));
      repeat (64) @(posedge clk_i);
      c = 65 >> d;
      chk(32'(int'(count_o) >= c - 1 && int'(count_o) <= c + 1), 32'h1);
    end
    complete_run();
  end
endmodule : free_run_timer_input_capture_bench
bind frt_icu frt_icu_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .count_o(count_o), .irq_o(irq_o), .ovf_irq_o(ovf_irq_o),
  .ovf_irq_num_o(ovf_irq_num_o), .xfer_req_o(xfer_req_o));
